// ===== logic/flash_mode_pkg.sv
package flash_mode_pkg;

  // register byte addresses
  localparam logic [7:0] MODE_CTRL_OFS = 8'h00;
  localparam logic [7:0] SETUP_FAULT_OFS = 8'h04;
  localparam logic [7:0] BLK_HI_OFS = 8'h08;
  localparam logic [7:0] BLK_LO_OFS = 8'h0C;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h10;
  localparam logic [7:0] IRQ_EN_OFS = 8'h14;
  localparam logic [7:0] IRQ_CLR_OFS = 8'h18;

  // values after reset
  localparam logic [7:0] MODE_CTRL_RST = 8'h80;
  localparam logic [7:0] SETUP_FAULT_RST = 8'h00;
  localparam logic [7:0] BLK_RST = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // mode_ctrl_one fields
  localparam int unsigned HW_GATE_BIT = 7;
  localparam int unsigned SOFT_GATE_BIT = 6;
  localparam int unsigned WIPE_CHECK_BIT = 3;
  localparam int unsigned WRITE_CHECK_BIT = 2;
  localparam int unsigned WIPE_BIT = 1;
  localparam int unsigned WRITE_BIT = 0;
  localparam logic [7:0] MODE_RW_MASK = 8'h4F;

  // setup_fault_ctrl fields
  localparam int unsigned FAULT_BIT = 7;
  localparam int unsigned WIPE_ARM_BIT = 1;
  localparam int unsigned WRITE_ARM_BIT = 0;
  localparam logic [7:0] SETUP_RW_MASK = 8'h03;

  // interrupt sources
  localparam int unsigned IRQ_W = 2;
  localparam int unsigned IRQ_FAULT = 0;
  localparam int unsigned IRQ_REFUSED = 1;
  localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;

  // state presented to the array
  typedef struct packed {
    logic protect;
    logic wipe_check;
    logic write_check;
    logic wipe;
    logic write;
    logic wipe_armed;
    logic write_armed;
  } array_mode_t;

  localparam array_mode_t ARRAY_MODE_RST = '0;

endpackage : flash_mode_pkg

// ===== logic/flash_mode_control_regs.sv
module flash_mode_control_regs
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rd_data,
  // power state, same clock domain
  input wire logic hw_standby,
  input wire logic lp_enter,
  // array side
  input wire logic fault_event,
  output flash_mode_pkg::array_mode_t array_mode,
  output logic [15:0] block_select,
  // interrupt
  output logic irq
);
  import flash_mode_pkg::*;

  logic [7:0] mode_r;
  logic [7:0] mode_nxt;
  logic [7:0] setup_r;
  logic [7:0] setup_nxt;
  logic [7:0] blk_hi_r;
  logic [7:0] blk_hi_nxt;
  logic [7:0] blk_lo_r;
  logic [7:0] blk_lo_nxt;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_stat_nxt;
  logic [IRQ_W-1:0] irq_en_r;
  logic [IRQ_W-1:0] irq_en_nxt;
  logic irq_r;
  logic [7:0] rd_data_r;
  logic [7:0] rd_data_nxt;
  array_mode_t array_mode_r;
  array_mode_t array_mode_nxt;

  // address decode
  wire sel_mode = (addr == MODE_CTRL_OFS);
  wire sel_setup = (addr == SETUP_FAULT_OFS);
  wire sel_blk_hi = (addr == BLK_HI_OFS);
  wire sel_blk_lo = (addr == BLK_LO_OFS);
  wire sel_stat = (addr == IRQ_STAT_OFS);
  wire sel_en = (addr == IRQ_EN_OFS);
  wire sel_clr = (addr == IRQ_CLR_OFS);
  wire wr_mode = wr_stb & sel_mode;
  wire wr_setup = wr_stb & sel_setup;
  wire wr_blk_hi = wr_stb & sel_blk_hi;
  wire wr_blk_lo = wr_stb & sel_blk_lo;
  wire wr_en = wr_stb & sel_en;
  wire wr_clr = wr_stb & sel_clr;

  // gates, judged on the stored state before this write
  wire soft_gate = mode_r[SOFT_GATE_BIT];
  wire wipe_armed = setup_r[WIPE_ARM_BIT];
  wire write_armed = setup_r[WRITE_ARM_BIT];
  wire fault = setup_r[FAULT_BIT];

  // per-bit permission to go from 0 to 1; clearing is always allowed
  wire [7:0] mode_allow;
  assign mode_allow[HW_GATE_BIT] = 1'b0;
  assign mode_allow[SOFT_GATE_BIT] = 1'b1;
  assign mode_allow[5:4] = 2'b00;
  assign mode_allow[WIPE_CHECK_BIT] = soft_gate;
  assign mode_allow[WRITE_CHECK_BIT] = soft_gate;
  assign mode_allow[WIPE_BIT] = soft_gate & wipe_armed;
  assign mode_allow[WRITE_BIT] = soft_gate & write_armed;

  wire [7:0] setup_allow = {6'b00_0000, soft_gate, soft_gate};
  wire [7:0] blk_allow = {8{soft_gate}};

  // written value after refusing forbidden sets
  wire [7:0] mode_keep = mode_r & ~MODE_RW_MASK;
  wire [7:0] mode_ok = wr_data & MODE_RW_MASK & (mode_r | mode_allow);
  wire [7:0] mode_wr_val = mode_keep | mode_ok;
  wire [7:0] setup_ok = wr_data & SETUP_RW_MASK & (setup_r | setup_allow);
  // reserved setup bits are held at zero whatever is written
  wire [7:0] setup_wr_val = (setup_r & ~SETUP_RW_MASK) | setup_ok;
  wire [7:0] blk_hi_ok = wr_data & (blk_hi_r | blk_allow);
  wire [7:0] blk_lo_ok = wr_data & (blk_lo_r | blk_allow);

  // attempts that were refused, for the interrupt status
  wire [7:0] mode_try = wr_data & MODE_RW_MASK & ~mode_r;
  wire [7:0] setup_try = wr_data & SETUP_RW_MASK & ~setup_r;
  wire [7:0] blk_hi_try = wr_data & ~blk_hi_r;
  wire [7:0] blk_lo_try = wr_data & ~blk_lo_r;
  wire mode_refused = wr_mode & (|(mode_try & ~mode_allow));
  wire setup_refused = wr_setup & (|(setup_try & ~setup_allow));
  wire blk_refused = (wr_blk_hi & (|(blk_hi_try & ~blk_allow)))
                   | (wr_blk_lo & (|(blk_lo_try & ~blk_allow)));
  wire refused = mode_refused | setup_refused | blk_refused;

  // soft gate being cleared by software
  wire gate_fall = wr_mode & soft_gate & ~wr_data[SOFT_GATE_BIT];

  // more than one block bit set clears both block registers
  wire [15:0] blk_cand = {wr_blk_hi ? blk_hi_ok : blk_hi_r,
                          wr_blk_lo ? blk_lo_ok : blk_lo_r};
  wire blk_multi = |(blk_cand & (blk_cand - 16'h0001));

  // mode register
  always_comb
  begin
    mode_nxt = mode_r;
    if (hw_standby | lp_enter)
    begin
      mode_nxt = MODE_CTRL_RST;
    end
    else if (wr_mode)
    begin
      mode_nxt = mode_wr_val;
    end
  end

  // setup and fault register
  always_comb
  begin
    setup_nxt = setup_r;
    if (hw_standby)
    begin
      setup_nxt = SETUP_FAULT_RST;
    end
    else
    begin
      if (wr_setup)
      begin
        setup_nxt = setup_wr_val;
      end
      if (lp_enter | gate_fall)
      begin
        setup_nxt = setup_nxt & ~SETUP_RW_MASK;
      end
      // the fault flag is sticky; only hardware standby or reset drop it
      setup_nxt[FAULT_BIT] = fault | fault_event;
    end
  end

  // block select registers
  always_comb
  begin
    blk_hi_nxt = blk_hi_r;
    blk_lo_nxt = blk_lo_r;
    if (hw_standby | lp_enter | gate_fall)
    begin
      blk_hi_nxt = BLK_RST;
      blk_lo_nxt = BLK_RST;
    end
    else if (blk_multi)
    begin
      blk_hi_nxt = BLK_RST;
      blk_lo_nxt = BLK_RST;
    end
    else
    begin
      blk_hi_nxt = blk_cand[15:8];
      blk_lo_nxt = blk_cand[7:0];
    end
  end

  // interrupt enable
  always_comb
  begin
    irq_en_nxt = irq_en_r;
    if (wr_en)
    begin
      irq_en_nxt = wr_data[IRQ_W-1:0];
    end
  end

  // sticky status, set wins over a clear in the same cycle
  wire [IRQ_W-1:0] irq_event;
  assign irq_event[IRQ_FAULT] = fault_event;
  assign irq_event[IRQ_REFUSED] = refused;

  genvar gi;
  generate
    for (gi = 0; gi < IRQ_W; gi++)
    begin : g_irq
      wire clr_bit = wr_clr & wr_data[gi];
      assign irq_stat_nxt[gi] = irq_event[gi] | (irq_stat_r[gi] & ~clr_bit);
    end
  endgenerate

  // array mode follows the committed register values; fault blocks
  // program and erase but leaves the verify reads usable
  always_comb
  begin
    array_mode_nxt = ARRAY_MODE_RST;
    array_mode_nxt.protect = setup_nxt[FAULT_BIT];
    array_mode_nxt.wipe_check = mode_nxt[WIPE_CHECK_BIT];
    array_mode_nxt.write_check = mode_nxt[WRITE_CHECK_BIT];
    array_mode_nxt.wipe = mode_nxt[WIPE_BIT] & ~setup_nxt[FAULT_BIT];
    array_mode_nxt.write = mode_nxt[WRITE_BIT] & ~setup_nxt[FAULT_BIT];
    array_mode_nxt.wipe_armed = setup_nxt[WIPE_ARM_BIT] & ~setup_nxt[FAULT_BIT];
    array_mode_nxt.write_armed = setup_nxt[WRITE_ARM_BIT] & ~setup_nxt[FAULT_BIT];
  end

  // read mux; the hardware gate reads as zero although it holds one
  wire [7:0] mode_rd = mode_r & MODE_RW_MASK;
  wire [7:0] stat_rd = {{(8 - IRQ_W){1'b0}}, irq_stat_r};
  wire [7:0] en_rd = {{(8 - IRQ_W){1'b0}}, irq_en_r};
  wire [7:0] rd_mux = sel_mode ? mode_rd
                    : sel_setup ? setup_r
                    : sel_blk_hi ? blk_hi_r
                    : sel_blk_lo ? blk_lo_r
                    : sel_stat ? stat_rd
                    : sel_en ? en_rd
                    : BYTE_ZERO;

  // read data stands for one cycle only
  assign rd_data_nxt = rd_stb ? rd_mux : BYTE_ZERO;

  // control registers
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mode_r <= MODE_CTRL_RST;
      setup_r <= SETUP_FAULT_RST;
    end
    else
    begin
      mode_r <= mode_nxt;
      setup_r <= setup_nxt;
    end
  end

  // block select registers
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      blk_hi_r <= BLK_RST;
      blk_lo_r <= BLK_RST;
    end
    else
    begin
      blk_hi_r <= blk_hi_nxt;
      blk_lo_r <= blk_lo_nxt;
    end
  end

  // interrupt state; irq looks at next-state values so it
  // rises at the same edge as the status bit, not one later
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      irq_stat_r <= IRQ_RST;
      irq_en_r <= IRQ_RST;
      irq_r <= 1'b0;
    end
    else
    begin
      irq_stat_r <= irq_stat_nxt;
      irq_en_r <= irq_en_nxt;
      irq_r <= |(irq_stat_nxt & irq_en_nxt);
    end
  end

  // registered outputs towards the bus and the array
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rd_data_r <= BYTE_ZERO;
      array_mode_r <= ARRAY_MODE_RST;
    end
    else
    begin
      rd_data_r <= rd_data_nxt;
      array_mode_r <= array_mode_nxt;
    end
  end

  assign rd_data = rd_data_r;
  assign array_mode = array_mode_r;
  assign block_select = {blk_hi_r, blk_lo_r};
  assign irq = irq_r;

endmodule : flash_mode_control_regs

// ===== verif/flash_mode_asserts.sv
module flash_mode_asserts
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] rd_data,
  // power and array
  input wire logic hw_standby,
  input wire logic lp_enter,
  input wire logic fault_event,
  input wire flash_mode_pkg::array_mode_t array_mode,
  input wire logic irq
);
  import flash_mode_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  wire mode_wr = wr_stb && addr == MODE_CTRL_OFS;
  wire setup_wr = wr_stb && addr == SETUP_FAULT_OFS;
  wire quiet = !lp_enter && !hw_standby;
  // bit 6 is the soft gate and reads back, only 7, 5 and 4 are fixed at zero
  a_mode_rd_zero: assert property (
    rd_stb && addr == MODE_CTRL_OFS |=> !rd_data[7] && rd_data[5:4] == 2'h0)
    else $error("mode fixed bits read nonzero");
  a_lp_clears_mode: assert property (
    lp_enter |=> array_mode[5:0] == 6'h00)
    else $error("low-power entry kept mode bits");
  a_standby_clears: assert property (
    hw_standby && !fault_event |=> array_mode == ARRAY_MODE_RST)
    else $error("standby left array state");
  a_gate_low_blocks: assert property (
    lp_enter ##1 (mode_wr && quiet) |=> array_mode[5:0] == 6'h00)
    else $error("mode bit set with gate low");
  a_wchk_cause: assert property (
    $rose(array_mode.wipe_check) |-> $past(mode_wr && wr_data[3]))
    else $error("erase check without write");
  a_pchk_cause: assert property (
    $rose(array_mode.write_check) |-> $past(mode_wr && wr_data[2]))
    else $error("program check without write");
  a_wipe_needs_arm: assert property (
    $rose(array_mode.wipe) |-> $past(mode_wr && wr_data[1] && array_mode.wipe_armed))
    else $error("erase without setup");
  a_write_needs_arm: assert property (
    $rose(array_mode.write) |-> $past(mode_wr && wr_data[0] && array_mode.write_armed))
    else $error("program without setup");
  a_arm_cause: assert property (
    $rose(array_mode.write_armed) |-> $past(setup_wr && wr_data[0]))
    else $error("program setup without write");
  a_fault_protects: assert property (
    fault_event && !hw_standby |=> array_mode.protect && !array_mode.wipe && !array_mode.write)
    else $error("fault did not protect");
  cover property (array_mode.write);
  cover property (array_mode.wipe);
  cover property (array_mode.wipe_check);
  cover property (irq);
endmodule : flash_mode_asserts

bind flash_mode_control_regs flash_mode_asserts chk (.sys_clk, .rstn, .addr, .wr_data, .wr_stb,
  .rd_stb, .rd_data, .hw_standby, .lp_enter, .fault_event, .array_mode, .irq);

// ===== verif/flash_mode_control_regs_tb_top.sv
`define CHK(g, e) \
  begin \
    n_checks++; \
    if ((g) !== (e)) \
    begin \
      mismatches++; \
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); \
    end \
  end

module flash_mode_control_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import flash_mode_pkg::*;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wr_data = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic hw_standby = 1'b0;
  logic lp_enter = 1'b0;
  logic fault_event = 1'b0;
  logic [7:0] rd_data;
  array_mode_t array_mode;
  logic [15:0] block_select;
  logic irq;
  logic pend = 1'b0;
  logic [7:0] exp_q[$];
  logic [7:0] exp_v;
  logic [7:0] d;
  int mismatches = 0;
  int n_checks = 0;

  flash_mode_control_regs dut (.sys_clk, .rstn, .addr, .wr_data, .wr_stb, .rd_stb, .rd_data,
    .hw_standby, .lp_enter, .fault_event, .array_mode, .block_select, .irq);

  initial forever #2 sys_clk = ~sys_clk;

  // read data stand only in the cycle after the strobe
  always @(posedge sys_clk) pend <= rd_stb;
  always @(negedge sys_clk)
    if (pend)
    begin
      exp_v = exp_q.pop_front();
      `CHK(rd_data, exp_v)
    end

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    addr <= a;
    wr_data <= v;
    wr_stb <= 1'b1;
    rd_stb <= 1'b0;
    @(posedge sys_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    addr <= a;
    rd_stb <= 1'b1;
    wr_stb <= 1'b0;
    exp_q.push_back(e);
    @(posedge sys_clk);
  endtask : rd

  task automatic nop(input int n);
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
    repeat (n) @(posedge sys_clk);
  endtask : nop

  // output looked at half a cycle on, so the stimulus stays on the rising edge
  task automatic chk_out(input int sel, input logic [15:0] e);
    fork
      begin
        @(negedge sys_clk);
        case (sel)
          0: `CHK(irq, e)
          1: `CHK(array_mode, e)
          default: `CHK(block_select, e)
        endcase
      end
    join_none
  endtask : chk_out

  task automatic done(input string s);
    nop(2);
    $display("test %s done", s);
  endtask : done

  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  initial
  begin
    repeat (2000) @(posedge sys_clk);
    mismatches++;
    print_verdict();
  end

  initial
  begin
    void'($urandom(3616));
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    rd(MODE_CTRL_OFS, 8'h00);
    rd(SETUP_FAULT_OFS, 8'h00);
    rd(8'h1C, 8'h00);
    // the soft gate reads zero after reset, so mode, setup and block sets are refused until it is written
    done("reset");
    // gate is judged before the write, so every mode bit but the soft gate is refused here
    for (int i = 0; i < 8; i++)
    begin
      d = 8'($urandom());
      wr(MODE_CTRL_OFS, d);
      rd(MODE_CTRL_OFS, d & 8'h40);
      wr(MODE_CTRL_OFS, 8'h00);
    end
    wr(IRQ_CLR_OFS, 8'h03);
    wr(MODE_CTRL_OFS, 8'h01);
    rd(IRQ_STAT_OFS, 8'h02);
    chk_out(0, 16'h0000);
    wr(IRQ_EN_OFS, 8'h02);
    nop(1);
    chk_out(0, 16'h0001);
    wr(IRQ_CLR_OFS, 8'h02);
    nop(1);
    chk_out(0, 16'h0000);
    done("refuse");
    wr(MODE_CTRL_OFS, 8'h40);
    wr(MODE_CTRL_OFS, 8'hFC);
    rd(MODE_CTRL_OFS, 8'h4C);
    wr(MODE_CTRL_OFS, 8'h40);
    wr(SETUP_FAULT_OFS, 8'h03);
    rd(SETUP_FAULT_OFS, 8'h03);
    wr(MODE_CTRL_OFS, 8'h43);
    rd(MODE_CTRL_OFS, 8'h43);
    chk_out(1, 16'h000F);
    d = 8'h01 << ($urandom() % 8);
    wr(BLK_LO_OFS, d);
    rd(BLK_LO_OFS, d);
    chk_out(2, {8'h00, d});
    wr(MODE_CTRL_OFS, 8'h40);
    wr(MODE_CTRL_OFS, 8'h00);
    rd(SETUP_FAULT_OFS, 8'h00);
    rd(BLK_LO_OFS, 8'h00);
    done("modes");
    wr(MODE_CTRL_OFS, 8'h40);
    wr(SETUP_FAULT_OFS, 8'h03);
    lp_enter <= 1'b1;
    nop(1);
    lp_enter <= 1'b0;
    wr(MODE_CTRL_OFS, 8'h4C);
    rd(MODE_CTRL_OFS, 8'h40);
    rd(SETUP_FAULT_OFS, 8'h00);
    wr(SETUP_FAULT_OFS, 8'h03);
    fault_event <= 1'b1;
    nop(1);
    fault_event <= 1'b0;
    rd(SETUP_FAULT_OFS, 8'h83);
    chk_out(1, 16'h0040);
    lp_enter <= 1'b1;
    nop(1);
    lp_enter <= 1'b0;
    rd(SETUP_FAULT_OFS, 8'h80);
    hw_standby <= 1'b1;
    nop(1);
    hw_standby <= 1'b0;
    rd(SETUP_FAULT_OFS, 8'h00);
    rd(MODE_CTRL_OFS, 8'h00);
    done("power");
    print_verdict();
  end
endmodule : flash_mode_control_regs_tb_top
